// *** design/spi_port_defines.svh ***
`ifndef SPI_PORT_DEFINES_SVH
`define SPI_PORT_DEFINES_SVH

// register offsets
`define SPI_OFF_DATA 8'h00
`define SPI_OFF_MATCH 8'h01
`define SPI_OFF_CTRL 8'h02

// control field positions
`define SPI_CTL_EN 0
`define SPI_CTL_DIV_LO 1
`define SPI_CTL_OVR 1
`define SPI_CTL_DIV_HI 2
`define SPI_CTL_DO_OFF 2
`define SPI_CTL_CMP_EN 3
`define SPI_CTL_RDY 4
`define SPI_CTL_FALL 5
`define SPI_CTL_TMR 6
`define SPI_CTL_MASTER 7

// reset values
`define SPI_CTL_RST 8'h00
`define SPI_MATCH_RST 8'h00

// timing counts: half periods of the divided clock minus one, then the last edge and last bit indices
`define SPI_HALF_DIV2 4'h0
`define SPI_HALF_DIV4 4'h1
`define SPI_HALF_DIV8 4'h3
`define SPI_HALF_DIV16 4'h7
`define SPI_EDGES_LAST 5'h0F
`define SPI_BIT_LAST 3'h7

`endif

// *** design/spi_port_pkg.sv ***
package spi_port_pkg;

    // master transfer engine
    typedef enum logic {
        M_IDLE,
        M_RUN
    } master_state_t;

endpackage : spi_port_pkg

// *** design/spi_master_slave_compare.sv ***
// Added by the designer: the plain strobed port.
`include "spi_port_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module spi_master_slave_compare (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // timer source
    input wire logic i_first_timer_output_out,
    // serial pins
    input wire logic i_serial_in_pin,
    input wire logic i_slave_select_b,
    input wire logic i_serial_clock_pin,
    output logic o_serial_clock_pin,
    output logic o_serial_clock_oe,
    output logic o_serial_out_pin,
    output logic o_serial_out_oe,
    // events
    output logic o_interrupt_line_three,
    output logic o_stop_wake_signal,
    output logic o_byte_ready_flag
);

    // half period limit from the divisor field
    function automatic logic [3:0] half_limit(input logic [1:0] sel);
        case (sel)
            2'h0: half_limit = `SPI_HALF_DIV2;
            2'h1: half_limit = `SPI_HALF_DIV4;
            2'h2: half_limit = `SPI_HALF_DIV8;
            default: half_limit = `SPI_HALF_DIV16;
        endcase
    endfunction : half_limit

    // software state
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    logic [7:0] match_q;
    logic [7:0] hold_q;
    logic rdy_q;
    logic [7:0] rdata_q;

    // shift registers
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic [7:0] tx_d;
    logic [7:0] rx_d;

    // master engine
    spi_port_pkg::master_state_t mst_q;
    spi_port_pkg::master_state_t mst_d;
    logic [3:0] half_q;
    logic [4:0] edge_q;
    logic sck_q;
    logic tmr_prev_q;

    // master receive delay line
    // the data pin reaches the shifter through the three pin stages and the
    // agreement filter, so a sample strobe taken straight off the clock edge
    // would read a bit that is two or more edges old at the fast divisors
    logic smp_d1_q;
    logic smp_d2_q;
    logic smp_d3_q;
    logic smp_d4_q;
    logic last_d1_q;
    logic last_d2_q;
    logic last_d3_q;
    logic last_d4_q;

    // slave engine
    logic [2:0] bit_q;
    logic cmp_phase_q;
    logic ignore_q;
    logic irq_q;
    logic wake_q;

    // pin synchronisers: sck, select, data in
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic [2:0] s3_q;
    logic [2:0] pin_q;
    logic [2:0] pin_d;
    logic sck_prev_q;
    logic ss_prev_q;

    // control field views
    wire en = ctl_q[`SPI_CTL_EN];
    wire master = ctl_q[`SPI_CTL_MASTER];
    wire fall_smp = ctl_q[`SPI_CTL_FALL];
    wire tmr_src = ctl_q[`SPI_CTL_TMR];
    wire cmp_en = ctl_q[`SPI_CTL_CMP_EN];
    wire do_off = ctl_q[`SPI_CTL_DO_OFF];

    // register decode
    wire wr_data = i_wr & (i_addr == `SPI_OFF_DATA);
    wire wr_match = i_wr & (i_addr == `SPI_OFF_MATCH);
    wire wr_ctl = i_wr & (i_addr == `SPI_OFF_CTRL);
    wire rd_data = i_rd & (i_addr == `SPI_OFF_DATA);

    // filtered pins; change accepted once stages two and three agree
    assign pin_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & pin_q);
    wire sck_f = pin_q[0];
    wire ss_act = ~pin_q[1];
    wire sdi_f = pin_q[2];

    // master clock generation, divided clock or timer output
    wire div_tick = (half_q == half_limit(ctl_q[2:1]));
    wire tmr_tick = i_first_timer_output_out & ~tmr_prev_q;
    wire m_run = (mst_q == spi_port_pkg::M_RUN);
    wire m_tick = m_run & (tmr_src ? tmr_tick : div_tick);
    wire m_rise = m_tick & ~sck_q;
    wire m_fall = m_tick & sck_q;
    wire m_smp = fall_smp ? m_fall : m_rise;
    wire m_drv = m_tick & ~m_smp & (edge_q != 5'h00);
    wire m_last = m_tick & (edge_q == `SPI_EDGES_LAST);
    wire m_start = wr_data & en & master & ~m_run;

    // delayed strobes line up with the filtered data pin
    wire m_smp_late = smp_d4_q;
    wire m_last_late = last_d4_q;

    // slave edges come from the master's clock pin
    wire s_sel = en & ~master & ss_act;
    wire s_rise = s_sel & sck_f & ~sck_prev_q;
    wire s_fall = s_sel & ~sck_f & sck_prev_q;
    wire s_smp = fall_smp ? s_fall : s_rise;
    wire s_drv = (fall_smp ? s_rise : s_fall) & (bit_q != 3'h0);
    wire s_live = s_smp & ~ignore_q;
    wire s_byte = s_live & (bit_q == `SPI_BIT_LAST);
    wire ss_begin = en & ~master & ss_act & ss_prev_q;

    // receive and compare outcome
    assign rx_d = (m_smp_late | s_live) ? {rx_q[6:0], sdi_f} : rx_q;
    wire cmp_done = s_byte & cmp_phase_q;
    wire cmp_hit = cmp_done & (rx_d == match_q);
    wire hold_ld = m_last_late | (s_byte & ~cmp_phase_q);
    wire ovr_set = s_byte & ~cmp_phase_q & rdy_q;

    // transmit: load on write, shift on drive edges
    always_comb begin
        tx_d = tx_q;
        if (wr_data & ~m_run) begin
            tx_d = i_wdata;
        end else if (m_drv | (s_drv & ~ignore_q)) begin
            tx_d = {tx_q[6:0], 1'b0};
        end
    end

    // master state sequencing
    always_comb begin
        mst_d = mst_q;
        case (mst_q)
            spi_port_pkg::M_IDLE: begin
                if (m_start) begin
                    mst_d = spi_port_pkg::M_RUN;
                end
            end
            spi_port_pkg::M_RUN: begin
                if (m_last | ~en | ~master) begin
                    mst_d = spi_port_pkg::M_IDLE;
                end
            end
            default: mst_d = spi_port_pkg::M_IDLE;
        endcase
    end

    // control write; overrun bit in slave mode only clears from software
    always_comb begin
        ctl_d = ctl_q;
        if (wr_ctl) begin
            ctl_d = i_wdata;
            ctl_d[`SPI_CTL_RDY] = 1'b0;
            if (~master) begin
                ctl_d[`SPI_CTL_OVR] = i_wdata[`SPI_CTL_OVR] & ctl_q[`SPI_CTL_OVR];
            end
        end
        if (ovr_set) begin
            ctl_d[`SPI_CTL_OVR] = 1'b1;
        end
    end

    // registers and read port
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctl_q <= `SPI_CTL_RST;
            match_q <= `SPI_MATCH_RST;
            hold_q <= 8'h00;
            rdy_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            ctl_q <= ctl_d;
            if (wr_match) begin
                match_q <= i_wdata;
            end
            if (hold_ld) begin
                hold_q <= rx_d;
            end
            // a new byte beats the clearing read
            rdy_q <= hold_ld | (rdy_q & ~rd_data);
            if (i_rd) begin
                case (i_addr)
                    `SPI_OFF_DATA: rdata_q <= hold_q;
                    `SPI_OFF_MATCH: rdata_q <= match_q;
                    `SPI_OFF_CTRL: rdata_q <= {ctl_q[7:5], rdy_q, ctl_q[3:0]};
                    default: rdata_q <= 8'h00;
                endcase
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    // pin synchronisers
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_q <= 3'h2;
            s2_q <= 3'h2;
            s3_q <= 3'h2;
            pin_q <= 3'h2;
            sck_prev_q <= 1'b0;
            ss_prev_q <= 1'b1;
            tmr_prev_q <= 1'b0;
        end else begin
            s1_q <= {i_serial_in_pin, i_slave_select_b, i_serial_clock_pin};
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= pin_d;
            sck_prev_q <= pin_q[0];
            ss_prev_q <= pin_q[1];
            tmr_prev_q <= i_first_timer_output_out;
        end
    end

    // master engine; clock idles low between transfers
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mst_q <= spi_port_pkg::M_IDLE;
            half_q <= 4'h0;
            edge_q <= 5'h00;
            sck_q <= 1'b0;
        end else begin
            mst_q <= mst_d;
            if (~m_run | m_start) begin
                half_q <= 4'h0;
                edge_q <= 5'h00;
                sck_q <= 1'b0;
            end else begin
                half_q <= div_tick ? 4'h0 : half_q + 4'h1;
                if (m_tick) begin
                    sck_q <= ~sck_q;
                    edge_q <= edge_q + 5'h01;
                end
            end
        end
    end

    // master sample delay, four stages to match pin stages plus filter
    // trade-off: the flag comes four cycles later, but every divisor reads cleanly
    // limitation: a new transfer must wait for the flag, as the tail still shifts
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            smp_d1_q <= 1'b0;
            smp_d2_q <= 1'b0;
            smp_d3_q <= 1'b0;
            smp_d4_q <= 1'b0;
            last_d1_q <= 1'b0;
            last_d2_q <= 1'b0;
            last_d3_q <= 1'b0;
            last_d4_q <= 1'b0;
        end else if (~en) begin
            // disabling drops a half-received byte
            smp_d1_q <= 1'b0;
            smp_d2_q <= 1'b0;
            smp_d3_q <= 1'b0;
            smp_d4_q <= 1'b0;
            last_d1_q <= 1'b0;
            last_d2_q <= 1'b0;
            last_d3_q <= 1'b0;
            last_d4_q <= 1'b0;
        end else begin
            smp_d1_q <= m_smp;
            smp_d2_q <= smp_d1_q;
            smp_d3_q <= smp_d2_q;
            smp_d4_q <= smp_d3_q;
            last_d1_q <= m_last;
            last_d2_q <= last_d1_q;
            last_d3_q <= last_d2_q;
            last_d4_q <= last_d3_q;
        end
    end

    // slave framing, compare and ignore state
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bit_q <= 3'h0;
            cmp_phase_q <= 1'b0;
            ignore_q <= 1'b0;
        end else if (~s_sel) begin
            bit_q <= 3'h0;
            cmp_phase_q <= 1'b0;
            ignore_q <= 1'b0;
        end else begin
            if (s_live) begin
                bit_q <= bit_q + 3'h1;
            end
            if (ss_begin) begin
                cmp_phase_q <= cmp_en;
            end else if (cmp_done) begin
                cmp_phase_q <= 1'b0;
            end
            if (cmp_done & ~cmp_hit) begin
                ignore_q <= 1'b1;
            end
        end
    end

    // shift data and event pulses
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_q <= 8'h00;
            tx_q <= 8'h00;
            irq_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            rx_q <= rx_d;
            tx_q <= tx_d;
            irq_q <= hold_ld;
            wake_q <= cmp_hit;
        end
    end

    // pin drive; data-out stays silent during compare and after mismatch
    wire s_do_on = ss_act & ~do_off & ~cmp_phase_q & ~ignore_q;
    assign o_serial_out_oe = en & (master | s_do_on);
    assign o_serial_out_pin = tx_q[7];
    assign o_serial_clock_pin = sck_q;
    assign o_serial_clock_oe = en & master;
    assign o_rdata = rdata_q;
    assign o_interrupt_line_three = irq_q;
    assign o_stop_wake_signal = wake_q;
    assign o_byte_ready_flag = rdy_q;

endmodule : spi_master_slave_compare

`default_nettype wire

// *** test/spi_port_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module spi_port_props (
    // clock, reset and register port
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // pins and events
    input wire logic i_first_timer_output_out,
    input wire logic i_serial_in_pin,
    input wire logic i_slave_select_b,
    input wire logic i_serial_clock_pin,
    input wire logic o_serial_clock_pin,
    input wire logic o_serial_clock_oe,
    input wire logic o_serial_out_pin,
    input wire logic o_serial_out_oe,
    input wire logic o_interrupt_line_three,
    input wire logic o_stop_wake_signal,
    input wire logic o_byte_ready_flag
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    // control write decode, shared by several checks
    wire ctl_wr = i_wr && i_addr == 8'h02;
    property p_off; ctl_wr && !i_wdata[0] |=> !o_serial_out_oe && !o_serial_clock_oe; endproperty
    a_off: assert property (p_off)
        else $error("pins driven while port disabled");
    property p_mst; ctl_wr && i_wdata[7] && i_wdata[0] |=> o_serial_clock_oe; endproperty
    a_mst: assert property (p_mst)
        else $error("master does not drive clock");
    property p_slv; ctl_wr && !i_wdata[7] |=> !o_serial_clock_oe; endproperty
    a_slv: assert property (p_slv)
        else $error("slave drives clock");
    property p_dooff; ctl_wr && i_wdata[3:0] == 4'h5 && !i_wdata[7] |=> !o_serial_out_oe; endproperty
    a_dooff: assert property (p_dooff)
        else $error("data out not released");
    property p_rdy; $rose(o_byte_ready_flag) |-> o_interrupt_line_three; endproperty
    a_rdy: assert property (p_rdy)
        else $error("ready without interrupt");
    property p_irq; o_interrupt_line_three |=> !o_interrupt_line_three; endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt longer than one cycle");
    property p_clr; i_rd && i_addr == 8'h00 |=> !o_byte_ready_flag || o_interrupt_line_three; endproperty
    a_clr: assert property (p_clr)
        else $error("ready not cleared by read");
    property p_bit4; i_rd && i_addr == 8'h02 |=> o_rdata[4] == $past(o_byte_ready_flag); endproperty
    a_bit4: assert property (p_bit4)
        else $error("control bit 4 differs from ready");
    property p_wake; o_stop_wake_signal |-> !o_interrupt_line_three ##1 !o_stop_wake_signal; endproperty
    a_wake: assert property (p_wake)
        else $error("wake pulse wrong");
endmodule : spi_port_props
bind spi_master_slave_compare spi_port_props i_spi_port_props (.*);
`default_nettype wire

// *** test/spi_far_end.sv ***
`timescale 1ns/10ps
`default_nettype none
module spi_far_end (
    // lines from the port
    input wire logic i_dut_sck,
    input wire logic i_dut_sdo,
    // lines towards the port
    output logic o_sck,
    output logic o_ss_b,
    output logic o_sdi
);
    logic [7:0] slave_q;
    logic [7:0] rx_q;
    logic mst_bit;
    logic driving;
    initial begin
        {o_sck, o_ss_b, mst_bit, driving, slave_q, rx_q} = {4'h4, 16'h0000};
    end
    // as slave: sample on rising, shift on falling, msb preloaded
    always @(posedge i_dut_sck) rx_q <= {rx_q[6:0], i_dut_sdo};
    always @(negedge i_dut_sck) slave_q <= {slave_q[6:0], ~slave_q[0]};
    assign o_sdi = driving ? mst_bit : slave_q[7];
    // as master: slow clock so the pin synchronisers keep up; still outside frames
    task automatic frame(input logic [15:0] w, input int n);
        o_ss_b = 1'b0;
        driving = 1'b1;
        #200;
        for (int i = 15; i > 15 - n; i--) begin
            mst_bit = w[i];
            #200 o_sck = 1'b1;
            #200 o_sck = 1'b0;
        end
        #200 o_ss_b = 1'b1;
        driving = 1'b0;
    endtask : frame
endmodule : spi_far_end
`default_nettype wire

// *** test/spi_master_slave_compare_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module spi_master_slave_compare_tb;
    logic i_sys_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_first_timer_output_out = 1'b0;
    logic [7:0] o_rdata;
    logic i_serial_in_pin, i_slave_select_b, i_serial_clock_pin, o_serial_clock_pin;
    logic o_serial_clock_oe, o_serial_out_pin, o_serial_out_oe, o_interrupt_line_three;
    logic o_stop_wake_signal, o_byte_ready_flag;
    logic [7:0] got;
    int fail_count = 0;
    int compares = 0;
    int irq_n = 0;
    int wake_n = 0;
    int cyc = 0;
    int n, b0, b1;
    always #10 i_sys_clk = ~i_sys_clk;
    spi_master_slave_compare i_spi_master_slave_compare (.*);
    spi_far_end i_spi_far_end (.i_dut_sck(o_serial_clock_pin), .i_dut_sdo(o_serial_out_pin),
        .o_sck(i_serial_clock_pin), .o_ss_b(i_slave_select_b), .o_sdi(i_serial_in_pin));
    // timer source, event counts and hang guard
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc % 3 == 0) i_first_timer_output_out <= ~i_first_timer_output_out;
        if (o_interrupt_line_three === 1'b1) irq_n++;
        if (o_stop_wake_signal === 1'b1) wake_n++;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask : check
    // read, mask and compare; data stand only in the cycle after the strobe
    task automatic rdck(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge i_sys_clk);
        {i_addr, i_rd} <= {a, 1'b1};
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 got = o_rdata;
        check(got & m, e);
    endtask : rdck
    task automatic results;
        $display("comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results
    initial begin
        repeat (8) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        rdck(8'h02, 8'hFF, 8'h00);
        rdck(8'h01, 8'hFF, 8'h00);
        rdck(8'h7F, 8'hFF, 8'h00);
        wr(8'h02, 8'h05);
        wr(8'h02, 8'h00);
        $display("test reset done");
        // four divisors, then the timer source
        for (int c = 0; c < 5; c++) begin
            i_spi_far_end.slave_q = 8'hA5;
            wr(8'h02, c < 4 ? 8'h81 | 8'(c << 1) : 8'hC1);
            wr(8'h00, 8'h3C);
            n = 0;
            while (o_byte_ready_flag !== 1'b1 && n < 400) begin
                @(posedge i_sys_clk);
                #1;
                n++;
            end
            compares++;
            if (c < 4 && (n < (16 << c) || n > (16 << c) + 8) || n == 400) begin
                fail_count++;
                $display("Error at %0t: transfer took %0d cycles", $time, n);
            end
            check(i_spi_far_end.rx_q, 8'h3C);
            rdck(8'h00, 8'hFF, 8'hA5);
            rdck(8'h02, 8'h10, 8'h00);
        end
        $display("test master done");
        wr(8'h02, 8'h01);
        b0 = irq_n;
        i_spi_far_end.frame({8'h5A, 8'hC3}, 16);
        repeat (8) @(posedge i_sys_clk);
        check(8'(irq_n - b0), 8'h02);
        rdck(8'h02, 8'h12, 8'h12);
        rdck(8'h00, 8'hFF, 8'hC3);
        wr(8'h02, 8'h03);
        rdck(8'h02, 8'h12, 8'h02);
        wr(8'h02, 8'h01);
        rdck(8'h02, 8'h12, 8'h00);
        $display("test slave done");
        wr(8'h01, 8'h42);
        wr(8'h02, 8'h09);
        {b0, b1} = {irq_n, wake_n};
        i_spi_far_end.frame({8'h13, 8'h55}, 16);
        repeat (8) @(posedge i_sys_clk);
        check(8'(irq_n - b0 + wake_n - b1), 8'h00);
        rdck(8'h02, 8'h10, 8'h00);
        i_spi_far_end.frame({8'h42, 8'h77}, 16);
        repeat (8) @(posedge i_sys_clk);
        check(8'(wake_n - b1), 8'h01);
        check(8'(irq_n - b0), 8'h01);
        rdck(8'h00, 8'hFF, 8'h77);
        $display("test compare done");
        results();
    end
endmodule : spi_master_slave_compare_tb
`default_nettype wire
